// file: rtl/mtc_pkg.sv
package mtc_pkg;

   // ******************************
   // Register map
   // ******************************
   localparam logic [7:0]  MTC_OFS_WAIT      = 8'h00;
   localparam logic [7:0]  MTC_OFS_DRAM      = 8'h04;
   localparam logic [7:0]  MTC_OFS_STATUS    = 8'h08;

   localparam logic [31:0] MTC_WAIT_RESET    = 32'h0777_7777;
   localparam logic [31:0] MTC_WAIT_MASK     = 32'h077f_77f7;
   localparam logic [31:0] MTC_DRAM_RESET    = 32'h0000_0000;
   localparam logic [31:0] MTC_DRAM_MASK     = 32'hf8bb_ffff;
   // Fields that may change after initialisation: refresh control and kind
   localparam logic [31:0] MTC_DRAM_LIVE     = 32'h0000_0006;

   // ******************************
   // Field positions
   // ******************************
   localparam int          MTC_ROW_OPEN_BIT  = 31;
   localparam int          MTC_PO_CMD_BIT    = 30;
   localparam int          MTC_BURST_BIT     = 9;
   localparam int          MTC_ST_INIT_BIT   = 0;
   localparam int          MTC_ST_REWR_BIT   = 1;
   localparam int          MTC_ST_BUSY_BIT   = 2;
   localparam logic [1:0]  MTC_SETUP_SUB     = 2'd2;
   localparam logic [1:0]  MTC_HOLD_SUB      = 2'd0;
   localparam logic [1:0]  MTC_HOLD_HI_SUB   = 2'd1;
   localparam logic [1:0]  MTC_RDH_SUB       = 2'd3;
   localparam logic [2:0]  MTC_RDH_AREA_A    = 3'd1;
   localparam logic [2:0]  MTC_RDH_AREA_B    = 3'd4;
   localparam logic [2:0]  MTC_AREA_LAST     = 3'd6;

   typedef enum logic [2:0] {
      MTC_IF_SRAM,
      MTC_IF_BCSRAM,
      MTC_IF_BROM,
      MTC_IF_DRAM,
      MTC_IF_SDRAM,
      MTC_IF_MPX
   } mtc_iface_t;

   typedef struct packed {
      logic [2:0] area;
      logic       write;
      mtc_iface_t iface;
      logic [3:0] wait_cycles;
   } mtc_acc_req_t;

   typedef struct packed {
      logic       setup;
      logic [1:0] hold;
      logic       rdh;
   } mtc_timing_t;

   typedef struct packed {
      logic addr_drive;
      logic wr_strobe;
      logic rd_strobe;
      logic sample;
      logic done;
   } mtc_strobe_t;

   function automatic logic [4:0] mtc_bit_pos(input logic [2:0] area,
                                              input logic [1:0] sub);
      mtc_bit_pos = {area, sub};
   endfunction

   function automatic logic mtc_uses_wait(input mtc_iface_t iface);
      mtc_uses_wait = (iface == MTC_IF_SRAM) || (iface == MTC_IF_BCSRAM) ||
                      (iface == MTC_IF_BROM);
   endfunction

endpackage

// file: rtl/mtc_area_decode.sv
`timescale 1ns/1ns
module mtc_area_decode (
   input  mtc_pkg::mtc_acc_req_t req_i,
   input  logic [31:0]           wait_reg_i,
   output mtc_pkg::mtc_timing_t  timing_o
);
   import mtc_pkg::*;

   always_comb begin
      timing_o = '0;
      if (mtc_uses_wait(req_i.iface) && req_i.area <= MTC_AREA_LAST) begin
         timing_o.setup   =
            wait_reg_i[mtc_bit_pos(req_i.area, MTC_SETUP_SUB)];
         timing_o.hold[1] =
            wait_reg_i[mtc_bit_pos(req_i.area, MTC_HOLD_HI_SUB)];
         timing_o.hold[0] =
            wait_reg_i[mtc_bit_pos(req_i.area, MTC_HOLD_SUB)];
         // Only plain SRAM in areas 1 and 4 honours early read negation; byte SRAM
         // ignores the bit whatever software writes to it
         if (req_i.iface == MTC_IF_SRAM &&
             (req_i.area == MTC_RDH_AREA_A || req_i.area == MTC_RDH_AREA_B)) begin
            timing_o.rdh =
               wait_reg_i[mtc_bit_pos(req_i.area, MTC_RDH_SUB)];
         end
      end
   end

endmodule

// file: rtl/mtc_cycle_count.sv
`timescale 1ns/1ns
module mtc_cycle_count (
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   input  wire logic       load_i,
   input  wire logic [3:0] value_i,
   output logic [3:0]      count_o,
   output logic            zero_o
);

   logic [3:0] count_q;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_q <= 4'h0;
      end else if (load_i) begin
         count_q <= value_i;
      end else if (count_q != 4'h0) begin
         count_q <= count_q - 4'h1;
      end
   end

   assign count_o = count_q;
   assign zero_o  = (count_q == 4'h0);

endmodule

// file: rtl/mtc_regs.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module mtc_regs (
   input  wire logic                  mclk_i,
   input  wire logic                  rst_b_i,
   // Register port
   input  wire logic [7:0]            addr_i,
   input  wire logic [31:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic [31:0]                rdata_o,
   // External access sequencing
   input  wire logic                  acc_req_i,
   input  mtc_pkg::mtc_acc_req_t      acc_i,
   output logic                       acc_ready_o,
   output mtc_pkg::mtc_strobe_t       strobe_o,
   // DRAM controls
   input  wire logic                  po_cmd_req_i,
   output logic                       po_precharge_all_o,
   output logic                       po_mode_set_o,
   output logic                       row_hold_open_o,
   output logic [31:0]                dram_cfg_o,
   output logic                       dram_init_done_o
);
   import mtc_pkg::*;

   // ******************************
   // Registers
   // ******************************
   logic [31:0] wait_q;
   logic [31:0] dram_q;
   logic        init_done_q;
   logic        rewrite_q;
   logic [31:0] rdata_q;

   logic        wr_wait;
   logic        wr_dram;
   logic        wr_status;
   logic        rewrite_set;
   logic        rewrite_clr;
   logic [31:0] dram_wval;

   assign wr_wait   = wr_i && (addr_i == MTC_OFS_WAIT);
   assign wr_dram   = wr_i && (addr_i == MTC_OFS_DRAM);
   assign wr_status = wr_i && (addr_i == MTC_OFS_STATUS);
   assign dram_wval = wdata_i & MTC_DRAM_MASK;

   // Only the power-on reset loads these with their reset values; a manual reset or standby does not
   // reach this block, so contents survive both
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_q <= MTC_WAIT_RESET;
      end else if (wr_wait) begin
         wait_q <= wdata_i & MTC_WAIT_MASK;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dram_q <= MTC_DRAM_RESET;
      end else if (wr_dram) begin
         dram_q <= dram_wval;
      end
   end

   // First write to the DRAM control register counts as initialisation
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         init_done_q <= 1'b0;
      end else if (wr_dram) begin
         init_done_q <= 1'b1;
      end
   end

   // A later write that alters any locked field is flagged for software;
   // the register still takes the value, hardware does not second-guess it
   assign rewrite_set = wr_dram && init_done_q &&
                        (((dram_wval ^ dram_q) & ~MTC_DRAM_LIVE) != 32'h0);
   assign rewrite_clr = wr_status && wdata_i[MTC_ST_REWR_BIT];

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rewrite_q <= 1'b0;
      end else if (rewrite_set) begin
         rewrite_q <= 1'b1;
      end else if (rewrite_clr) begin
         rewrite_q <= 1'b0;
      end
   end

   // ******************************
   // Read port
   // ******************************
   logic busy;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= 32'h0;
      end else if (rd_i) begin
         case (addr_i)
            MTC_OFS_WAIT:   rdata_q <= wait_q & MTC_WAIT_MASK;
            MTC_OFS_DRAM:   rdata_q <= dram_q & MTC_DRAM_MASK;
            MTC_OFS_STATUS: begin
               rdata_q                  <= 32'h0;
               rdata_q[MTC_ST_INIT_BIT] <= init_done_q;
               rdata_q[MTC_ST_REWR_BIT] <= rewrite_q;
               rdata_q[MTC_ST_BUSY_BIT] <= busy;
            end
            default:        rdata_q <= 32'h0;
         endcase
      end else begin
         rdata_q <= 32'h0;
      end
   end

   assign rdata_o = rdata_q;

   // ******************************
   // Access sequencer
   // ******************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD
   } mtc_state_t;

   mtc_state_t   state_q;
   mtc_state_t   state_d;
   mtc_acc_req_t req_q;
   mtc_timing_t  tim_new;
   mtc_timing_t  tim_q;
   logic         cnt_load;
   logic [3:0]   cnt_value;
   logic         cnt_zero;
   logic         start;
   logic         done_q;

   mtc_area_decode u_decode (
      .req_i      (acc_i),
      .wait_reg_i (wait_q),
      .timing_o   (tim_new)
   );

   mtc_cycle_count u_count (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .load_i  (cnt_load),
      .value_i (cnt_value),
      .count_o (),
      .zero_o  (cnt_zero)
   );

   assign acc_ready_o = (state_q == ST_IDLE);
   assign start       = acc_req_i && acc_ready_o;
   assign busy        = !acc_ready_o;

   // Settings are captured when the access starts, so a register write
   // mid-access only shows on the next one
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         req_q <= '0;
         tim_q <= '0;
      end else if (start) begin
         req_q <= acc_i;
         tim_q <= tim_new;
      end
   end

   always_comb begin
      state_d   = state_q;
      cnt_load  = 1'b0;
      cnt_value = 4'h0;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               cnt_load = 1'b1;
               if (tim_new.setup) begin
                  state_d = ST_SETUP;
               end else begin
                  state_d   = ST_STROBE;
                  cnt_value = acc_i.wait_cycles;
               end
            end
         end
         ST_SETUP: begin
            state_d   = ST_STROBE;
            cnt_load  = 1'b1;
            cnt_value = req_q.wait_cycles;
         end
         ST_STROBE: begin
            if (cnt_zero) begin
               if (tim_q.hold != 2'd0) begin
                  state_d   = ST_HOLD;
                  cnt_load  = 1'b1;
                  cnt_value = {2'b00, tim_q.hold - 2'd1};
               end else begin
                  state_d = ST_IDLE;
               end
            end
         end
         ST_HOLD: begin
            if (cnt_zero) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_q <= 1'b0;
      end else begin
         done_q <= busy && (state_d == ST_IDLE);
      end
   end

   always_comb begin
      strobe_o            = '0;
      strobe_o.addr_drive = busy;
      strobe_o.done       = done_q;
      case (state_q)
         ST_STROBE: begin
            strobe_o.wr_strobe = req_q.write;
            strobe_o.rd_strobe = !req_q.write;
            strobe_o.sample    = !req_q.write && cnt_zero;
         end
         ST_HOLD: begin
            // Read strobe stays out through hold unless early negation is set
            strobe_o.rd_strobe = !req_q.write && !tim_q.rdh;
         end
         default: begin
            strobe_o.wr_strobe = 1'b0;
         end
      endcase
   end

   // ******************************
   // DRAM controls
   // ******************************
   assign row_hold_open_o  = dram_q[MTC_ROW_OPEN_BIT];
   assign dram_cfg_o       = dram_q;
   assign dram_init_done_o = init_done_q;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         po_precharge_all_o <= 1'b0;
         po_mode_set_o      <= 1'b0;
      end else begin
         po_precharge_all_o <= po_cmd_req_i && !dram_q[MTC_PO_CMD_BIT];
         po_mode_set_o      <= po_cmd_req_i && dram_q[MTC_PO_CMD_BIT];
      end
   end

endmodule

// file: verification/mtc_regs_monitor.sv
`timescale 1ns/1ns
module mtc_regs_monitor (
   input wire logic           mclk_i,
   input wire logic           rst_b_i,
   input wire logic [7:0]     addr_i,
   input wire logic [31:0]    wdata_i,
   input wire logic           wr_i,
   input wire logic           rd_i,
   input wire logic [31:0]    rdata_o,
   input wire logic           acc_req_i,
   input mtc_pkg::mtc_acc_req_t acc_i,
   input wire logic           acc_ready_o,
   input mtc_pkg::mtc_strobe_t strobe_o,
   input wire logic           po_cmd_req_i,
   input wire logic           po_precharge_all_o,
   input wire logic           po_mode_set_o,
   input wire logic           row_hold_open_o,
   input wire logic [31:0]    dram_cfg_o
);
   import mtc_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   a_wait_reserved: assert property (
      $past(rd_i) && $past(addr_i) == 8'h00 |-> (rdata_o & 32'hf880_8808) == 0)
      else $error("wait register reserved bit set");
   a_dram_readback: assert property (
      $past(rd_i) && $past(addr_i) == 8'h04 |-> rdata_o == $past(dram_cfg_o))
      else $error("dram control readback differs");
   a_row_open_write: assert property (
      wr_i && addr_i == MTC_OFS_DRAM
      |=> row_hold_open_o == $past(wdata_i[31]))
      else $error("row-open output does not follow bit 31 write");
   a_precharge_cmd: assert property (
      po_cmd_req_i && !dram_cfg_o[30] |=> po_precharge_all_o && !po_mode_set_o)
      else $error("precharge-all command missing");
   a_mode_set_cmd: assert property (
      po_cmd_req_i && dram_cfg_o[30] |=> po_mode_set_o && !po_precharge_all_o)
      else $error("mode-set command missing");
   a_no_setup_dram: assert property (
      acc_req_i && acc_ready_o && acc_i.iface >= MTC_IF_DRAM
      |=> strobe_o.wr_strobe || strobe_o.rd_strobe)
      else $error("setup inserted on non-SRAM interface");
   a_sample_last: assert property (
      strobe_o.sample |-> strobe_o.rd_strobe ##1 !strobe_o.sample)
      else $error("sample not on last read strobe cycle");
   a_read_hold: assert property (
      strobe_o.sample |-> ##[1:4] strobe_o.done)
      else $error("read hold longer than three cycles");
   a_write_hold: assert property (
      $fell(strobe_o.wr_strobe) |-> ##[0:3] strobe_o.done)
      else $error("write hold longer than three cycles");

   c_read: cover property (strobe_o.sample);
   c_mode_set: cover property (po_mode_set_o);
   c_long_hold: cover property ($fell(strobe_o.wr_strobe) ##3 strobe_o.done);
endmodule

bind mtc_regs mtc_regs_monitor i_mtc_regs_monitor (.mclk_i, .rst_b_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .acc_req_i, .acc_i,
   .acc_ready_o, .strobe_o,
   .po_cmd_req_i, .po_precharge_all_o, .po_mode_set_o, .row_hold_open_o,
   .dram_cfg_o);

// file: verification/mtc_mem_model.sv
`timescale 1ns/1ns
module mtc_mem_model (
   input  wire logic            mclk_i,
   input  wire logic            rst_b_i,
   input  mtc_pkg::mtc_strobe_t strobe_i,
   output logic [15:0]          shape_o
);
   import mtc_pkg::*;
   logic [3:0] set_q, str_q, hld_q, rdh_q;
   logic       post_q;

   // Memory side: measures setup, strobe, hold and read-strobe tail.
   // Result is latched on done so the bench can read it at leisure.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {set_q, str_q, hld_q, rdh_q, post_q} <= '0;
         shape_o <= '0;
      end else if (strobe_i.done) begin
         shape_o <= {set_q, str_q, hld_q, rdh_q};
         {set_q, str_q, hld_q, rdh_q, post_q} <= '0;
      end else begin
         if (strobe_i.wr_strobe || (strobe_i.rd_strobe && !post_q))
            str_q <= str_q + 4'h1;
         else if (strobe_i.addr_drive && !post_q)
            set_q <= set_q + 4'h1;
         if (post_q && strobe_i.addr_drive && !strobe_i.wr_strobe)
            hld_q <= hld_q + 4'h1;
         if (post_q && strobe_i.rd_strobe)
            rdh_q <= rdh_q + 4'h1;
         if (strobe_i.wr_strobe || strobe_i.sample)
            post_q <= 1'b1;
      end
   end
endmodule

// file: verification/mtc_regs_test.sv
`timescale 1ns/1ns
module mtc_regs_test;
   import mtc_pkg::*;
   logic         mclk_i = 1'b0;
   logic         rst_b_i = 1'b0;
   logic [7:0]   addr = 8'h00;
   logic [31:0]  wdata = '0;
   logic         wr = 1'b0;
   logic         rd = 1'b0;
   logic         acc_req = 1'b0;
   mtc_acc_req_t acc = '0;
   logic         po_req = 1'b0;
   logic [31:0]  rdata, cfg;
   logic         ready, pre, mset, row, init;
   mtc_strobe_t  strb;
   logic [15:0]  shape;
   int           err_total = 0;
   int           checks_done = 0;

   always #4 mclk_i = ~mclk_i;

   mtc_regs i_mtc_regs (.mclk_i, .rst_b_i, .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .acc_req_i(acc_req),
      .acc_i(acc), .acc_ready_o(ready), .strobe_o(strb),
      .po_cmd_req_i(po_req), .po_precharge_all_o(pre),
      .po_mode_set_o(mset), .row_hold_open_o(row), .dram_cfg_o(cfg),
      .dram_init_done_o(init));

   mtc_mem_model i_mtc_mem_model (.mclk_i, .rst_b_i, .strobe_i(strb),
      .shape_o(shape));

   // ****************************************
   // Bus tasks and compare
   // ****************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task end_of_test;
      $display("mismatches=%0d checks=%0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task wrr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
      #1;
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   // Expected shape is {setup, strobe, hold, read tail} in cycles
   task run(input logic [2:0] a, input logic w, input mtc_iface_t f,
            input logic [3:0] wc, input logic [15:0] e);
      int i;
      @(posedge mclk_i);
      acc_req <= 1'b1;
      acc <= '{a, w, f, wc};
      @(posedge mclk_i);
      acc_req <= 1'b0;
      for (i = 0; i < 40; i++) begin
         #1;
         if (strb.done === 1'b1) break;
         @(posedge mclk_i);
      end
      if (i == 40) begin
         err_total++;
         end_of_test;
      end
      chk({31'h0, ready}, 32'h1);
      @(posedge mclk_i);
      #1;
      chk({16'h0, shape}, {16'h0, e});
   endtask

   task po(input logic e);
      @(posedge mclk_i);
      po_req <= 1'b1;
      @(posedge mclk_i);
      po_req <= 1'b0;
      #1;
      chk({30'h0, pre, mset}, {30'h0, e, ~e});
   endtask

   initial begin
      int h;
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rdc(8'h00, 32'h0777_7777);
      rdc(8'h04, 32'h0000_0000);
      rdc(8'h0c, 32'h0000_0000);
      run(3'd0, 1'b1, MTC_IF_SRAM, 4'd0, 16'h1130);
      run(3'd6, 1'b0, MTC_IF_BROM, 4'd2, 16'h1333);
      wrr(8'h00, 32'hffff_ffff);
      rdc(8'h00, 32'h077f_77f7);
      for (h = 0; h < 4; h++) begin
         wrr(8'h00, {9'h0, h[0], h[1:0], 20'h0});
         run(3'd5, 1'b1, MTC_IF_BCSRAM, 4'd1,
             {3'h0, h[0], 4'h2, 2'h0, h[1:0], 4'h0});
      end
      for (h = 0; h < 4; h++) begin
         wrr(8'h00, {12'h0, h[0], 3'h2, 8'h0, h[0], 3'h2, 4'h0});
         run(h[1] ? 3'd4 : 3'd1, 1'b0, MTC_IF_SRAM, 4'd0,
             {8'h01, 4'h2, h[0] ? 4'h0 : 4'h2});
      end
      // Byte-control SRAM in area 4 with the negate select written clear: read strobe runs through hold
      wrr(8'h00, 32'h0002_0020);
      run(3'd4, 1'b0, MTC_IF_BCSRAM, 4'd0, 16'h0122);
      // Before initialisation: precharge-all command, status clear
      chk({30'h0, row, init}, 32'h0);
      po(1'b1);
      rdc(8'h08, 32'h0000_0000);
      // One initialisation write: row-open with burst enable, mode-set
      wrr(8'h04, 32'hc000_0200);
      chk(cfg, 32'hc000_0200);
      rdc(8'h04, 32'hc000_0200);
      chk({30'h0, row, init}, 32'h3);
      po(1'b0);
      // DRAM-type areas are only touched once initialisation is done
      for (h = 3; h < 6; h++)
         run(3'd2, 1'b1, mtc_iface_t'(h[2:0]), 4'd0, 16'h0100);
      // Refresh update rewrites every other field with its current value
      wrr(8'h04, 32'hc000_0206);
      rdc(8'h08, 32'h0000_0001);
      // A second power-on reset must restore both registers
      wrr(8'h00, 32'h0000_0000);
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rdc(8'h00, 32'h0777_7777);
      rdc(8'h04, 32'h0000_0000);
      rdc(8'h08, 32'h0000_0000);
      end_of_test;
   end
endmodule
